/* File: core/eaf_pkg.sv */
/*
 * Shared constants for the front-end control register block: serial word
 * layout, register addresses, field positions, masks and reset values.
 * Assumes a single 24-bit register space reached by 32-bit serial words.
 */
package eaf_pkg;
   // Serial word layout
   localparam int FRAME_BITS = 32;
   localparam int RW_POS = 31;
   localparam int ADDR_HI = 30;
   localparam int ADDR_LO = 24;
   localparam int DATA_HI = 23;
   // Register addresses
   localparam logic [6:0] ADDR_NOP = 7'h00;
   localparam logic [6:0] ADDR_MAIN = 7'h01;
   localparam logic [6:0] ADDR_LOFF = 7'h02;
   // Reset values
   localparam logic [23:0] MAIN_RST = 24'h000000;
   localparam logic [23:0] LOFF_RST = 24'h000000;
   // Writable bits; reserved bits are held at zero
   localparam logic [23:0] MAIN_WMASK = 24'hF807FF;
   localparam logic [23:0] LOFF_WMASK = 24'hFFF19F;
   // Main control field positions
   localparam int GAIN_HI = 9;
   localparam int GAIN_LO = 8;
   localparam int REFBUF_POS = 7;
   localparam int EXTCLK_POS = 6;
   localparam int MASTER_POS = 5;
   localparam int GANG_POS = 4;
   localparam int HIRATE_POS = 3;
   localparam int CONV_POS = 2;
   localparam int PWR_POS = 1;
   localparam int SRST_POS = 0;
   // Gain codes
   localparam logic [1:0] GAIN_X2P8 = 2'h2;
   localparam logic [1:0] GAIN_X4P2 = 2'h3;
endpackage : eaf_pkg

/* File: core/eaf_link_if.sv */
/*
 * Carrier between the serial link logic and the register core.
 * Assumes word is frozen while done is high and rdata is quasi-static.
 */
interface eaf_link_if;
   logic [31:0] word;   // Received serial word
   logic done;          // High from the 32nd bit until select rises
   logic [31:0] rdata;  // Word returned in the next frame

   modport link (output word, output done, input rdata);
   modport core (input word, input done, output rdata);
endinterface : eaf_link_if

/* File: core/eaf_link.sv */
/*
 * Serial link end, clocked by the host's serial clock. Shifts in one
 * 32-bit word MSB first, flags completion, and shifts out the answer.
 * Assumes the serial clock only runs while select is low.
 */
module eaf_link
   import eaf_pkg::*;
(
   // Link pins
   input wire logic link_clk_in,
   input wire logic cs_n_in,
   input wire logic sdi_in,
   output logic sdo_out,
   // Core side
   eaf_link_if.link lk
);
   logic [5:0] cnt_q;
   logic done_q;
   logic [31:0] shift_q;
   logic sdo_q;
   wire [4:0] out_idx = 5'(RW_POS - int'(cnt_q));

   // Bit counter; select high ends the frame since the clock may stop
   always_ff @(posedge link_clk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         cnt_q <= 6'h00;
         done_q <= 1'b0;
      end else if (!done_q) begin
         cnt_q <= cnt_q + 6'h01;
         done_q <= (cnt_q == 6'(FRAME_BITS - 1));
      end
   end

   // Shift in MSB first; frozen after the last bit so the core reads it safely
   always_ff @(posedge link_clk_in) begin
      if (!cs_n_in && !done_q) begin
         shift_q <= {shift_q[30:0], sdi_in};
      end
   end

   // Answer changes on the falling edge; its first bit is the flag, always 0
   always_ff @(negedge link_clk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         sdo_q <= 1'b0;
      end else begin
         sdo_q <= done_q ? 1'b0 : lk.rdata[out_idx];
      end
   end

   assign lk.word = shift_q;
   assign lk.done = done_q;
   assign sdo_out = sdo_q;
endmodule : eaf_link

/* File: core/eaf_ctl_decode.sv */
/*
 * Decodes the main control register into the front end's control levels.
 * Purely combinational; the top registers every result.
 */
module eaf_ctl_decode
   import eaf_pkg::*;
#(
   parameter bit SLAVE_ONLY = 1'b0
)
(
   // Register and calibration state
   input wire logic [23:0] ctl_in,
   input wire logic gain_cal_done_in,
   // Decoded levels
   output logic [1:0] gain_out,
   output logic master_out,
   output logic crystal_en_out,
   output logic clk_io_oe_out,
   output logic conv_run_out
);
   wire gang = ctl_in[GANG_POS];
   wire power = ctl_in[PWR_POS];
   wire [1:0] gain_code = ctl_in[GAIN_HI:GAIN_LO];
   wire is_slave = gang && !master_out;

   // Uncalibrated top gain falls back to the next step rather than clipping
   assign gain_out = (gain_code == GAIN_X4P2 && !gain_cal_done_in) ? GAIN_X2P8 : gain_code;
   // Master only in gang mode, never on the slave-only variant
   assign master_out = gang && ctl_in[MASTER_POS] && !SLAVE_ONLY;
   // Crystal runs only when powered, selected, and not a gang slave
   assign crystal_en_out = power && !ctl_in[EXTCLK_POS] && !is_slave;
   // The master drives the shared clock while powered, slaves listen on it
   assign clk_io_oe_out = master_out && power;
   assign conv_run_out = ctl_in[CONV_POS] && power;
endmodule : eaf_ctl_decode

/* File: core/eaf_main_control.sv */
/*
 * Main control register bank of the front end, reached over a 32-bit serial
 * link, with the lead-off control register beside it. Holds the register
 * state, handles the two-step software reset and registers all control
 * levels. Assumes the link clock stops between frames, select stays high
 * for at least 4 core clocks between frames, and the core clock is the faster.
 */

module eaf_main_control
   import eaf_pkg::*;
#(
   parameter bit SLAVE_ONLY = 1'b0
)
(
   // Core clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // Serial link pins
   input wire logic link_clk_in,
   input wire logic cs_n_in,
   input wire logic sdi_in,
   output logic sdo_out,
   // Calibration status from the gain calibration logic
   input wire logic gain_cal_done_in,
   // Analog and clock control levels
   output logic [1:0] gain_out,
   output logic reference_buffer_en_out,
   output logic external_clock_sel_out,
   output logic crystal_oscillator_en_out,
   output logic clk_io_oe_out,
   output logic sync_active_out,
   output logic sync_oe_out,
   output logic master_active_out,
   output logic high_rate_sel_out,
   output logic conversion_run_out,
   output logic analog_power_out,
   output logic soft_reset_pend_out,
   // Raw register contents for the channel and lead-off logic
   output logic [23:0] main_control_out,
   output logic [23:0] lead_off_control_out
);
   eaf_link_if lk ();

   logic done_s1_q;
   logic done_s2_q;
   logic done_s3_q;
   logic [23:0] main_q;
   logic [23:0] main_d;
   logic [23:0] loff_q;
   logic [23:0] loff_d;
   logic pend_q;
   logic pend_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0] gain_w;
   logic master_w;
   logic crystal_w;
   logic clkio_w;
   logic conv_w;
   logic sdo_w;

   // Link end runs on the host's clock
   eaf_link u_link (
      .link_clk_in (link_clk_in),
      .cs_n_in (cs_n_in),
      .sdi_in (sdi_in),
      .sdo_out (sdo_w),
      .lk (lk.link)
   );

   // Control decode for the gain, master, crystal, clock pin and conversion levels
   eaf_ctl_decode #(
      .SLAVE_ONLY (SLAVE_ONLY)
   ) u_decode (
      .ctl_in (main_q),
      .gain_cal_done_in (gain_cal_done_in),
      .gain_out (gain_w),
      .master_out (master_w),
      .crystal_en_out (crystal_w),
      .clk_io_oe_out (clkio_w),
      .conv_run_out (conv_w)
   );

   // Done level crosses by two flops; the word is frozen while it is high
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         done_s3_q <= 1'b0;
      end else begin
         done_s1_q <= lk.done;
         done_s2_q <= done_s1_q;
         done_s3_q <= done_s2_q;
      end
   end

   // Frame decode from the frozen word
   wire frame_stb = done_s2_q && !done_s3_q;
   wire fr_write = lk.word[RW_POS];
   wire [6:0] fr_addr = lk.word[ADDR_HI:ADDR_LO];
   wire [23:0] fr_data = lk.word[DATA_HI:0];
   wire wr_main = frame_stb && !pend_q && fr_write && fr_addr == ADDR_MAIN;
   wire wr_loff = frame_stb && !pend_q && fr_write && fr_addr == ADDR_LOFF;
   wire rd_frame = frame_stb && !pend_q && !fr_write;
   // Bit 0 is never stored; a frame while pending completes the reset instead of a read, so it reads back as 0
   wire [23:0] main_view = main_q | {23'h000000, pend_q};
   wire [23:0] rd_sel = (fr_addr == ADDR_MAIN) ? main_view :
                        (fr_addr == ADDR_LOFF) ? loff_q : 24'h000000;

   // Next register state. The frame after a reset request completes it and
   // is itself discarded, so the host's no-operation frame finishes the job.
   always_comb begin
      main_d = main_q;
      loff_d = loff_q;
      pend_d = pend_q;
      rdata_d = rdata_q;
      if (frame_stb && pend_q) begin
         main_d = MAIN_RST;
         loff_d = LOFF_RST;
         pend_d = 1'b0;
         rdata_d = 32'h00000000;
      end else begin
         if (wr_main) begin
            main_d = fr_data & MAIN_WMASK & ~(24'h000001 << SRST_POS);
            pend_d = fr_data[SRST_POS];
         end
         if (wr_loff) begin
            loff_d = fr_data & LOFF_WMASK;
         end
         if (rd_frame) begin
            rdata_d = {1'b0, fr_addr, rd_sel};
         end
      end
   end

   // Register state; power down never touches it, only resets do
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         main_q <= MAIN_RST;
         loff_q <= LOFF_RST;
         pend_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         main_q <= main_d;
         loff_q <= loff_d;
         pend_q <= pend_d;
         rdata_q <= rdata_d;
      end
   end

   // Read word held steady for the link to shift out in the next frame
   assign lk.rdata = rdata_q;
   assign sdo_out = sdo_w;

   // Registered control levels
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         gain_out <= 2'h0;
         reference_buffer_en_out <= 1'b0;
         external_clock_sel_out <= 1'b0;
         crystal_oscillator_en_out <= 1'b0;
         clk_io_oe_out <= 1'b0;
         sync_active_out <= 1'b0;
         sync_oe_out <= 1'b0;
         master_active_out <= 1'b0;
      end else begin
         gain_out <= gain_w;
         reference_buffer_en_out <= main_q[REFBUF_POS];
         external_clock_sel_out <= main_q[EXTCLK_POS] || (main_q[GANG_POS] && !master_w);
         crystal_oscillator_en_out <= crystal_w;
         clk_io_oe_out <= clkio_w;
         sync_active_out <= main_q[GANG_POS];
         sync_oe_out <= master_w;
         master_active_out <= master_w;
      end
   end

   // More registered levels and raw register views
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         high_rate_sel_out <= 1'b0;
         conversion_run_out <= 1'b0;
         analog_power_out <= 1'b0;
         soft_reset_pend_out <= 1'b0;
         main_control_out <= MAIN_RST;
         lead_off_control_out <= LOFF_RST;
      end else begin
         high_rate_sel_out <= main_q[HIRATE_POS];
         conversion_run_out <= conv_w;
         analog_power_out <= main_q[PWR_POS];
         soft_reset_pend_out <= pend_q;
         main_control_out <= main_q;
         lead_off_control_out <= loff_q;
      end
   end

   // Checks, all in the core clock domain
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);

   property p_gain;
      (main_q[GAIN_HI:GAIN_LO] == GAIN_X4P2 && !gain_cal_done_in)
         |=> gain_out == GAIN_X2P8;
   endproperty
   a_gain: assert property (p_gain) else $error("uncalibrated gain not held back");

   property p_clk_src;
      (main_q[EXTCLK_POS] && !$past(srst_in)) |=> external_clock_sel_out && !crystal_oscillator_en_out;
   endproperty
   a_clk_src: assert property (p_clk_src) else $error("external clock select ignored");

   property p_slave_crystal_oscillator;
      (main_q[GANG_POS] && !master_w) |=> !crystal_oscillator_en_out && external_clock_sel_out;
   endproperty
   a_slave_crystal_oscillator: assert property (p_slave_crystal_oscillator) else $error("gang slave kept its crystal");

   property p_master;
      (main_q[GANG_POS] && main_q[MASTER_POS] && !SLAVE_ONLY)
         |=> master_active_out && sync_oe_out;
   endproperty
   a_master: assert property (p_master) else $error("master not taken in gang mode");

   property p_single_ignore;
      !main_q[GANG_POS] |=> !master_active_out && !sync_oe_out && !sync_active_out;
   endproperty
   a_single_ignore: assert property (p_single_ignore) else $error("master outside gang mode");

   property p_slave_only;
      (SLAVE_ONLY != 0) |-> !master_active_out && !clk_io_oe_out;
   endproperty
   a_slave_only: assert property (p_slave_only) else $error("slave-only part acted as master");

   property p_gang_pins;
      $rose(main_q[GANG_POS]) |=> sync_active_out;
   endproperty
   a_gang_pins: assert property (p_gang_pins) else $error("gang pins not activated");

   property p_rate;
      $changed(main_q[HIRATE_POS]) |=> high_rate_sel_out == $past(main_q[HIRATE_POS]);
   endproperty
   a_rate: assert property (p_rate) else $error("rate select did not follow");

   property p_conv_idle;
      !main_q[CONV_POS] |=> !conversion_run_out;
   endproperty
   a_conv_idle: assert property (p_conv_idle) else $error("conversion ran while idle");

   property p_power_down;
      !main_q[PWR_POS] [*2] |-> !analog_power_out && !crystal_oscillator_en_out && !conversion_run_out;
   endproperty
   a_power_down: assert property (p_power_down) else $error("analog left on in power down");

   property p_retain;
      (!frame_stb && !pend_q) |=> main_q == $past(main_q) && loff_q == $past(loff_q);
   endproperty
   a_retain: assert property (p_retain) else $error("register changed without a frame");

   property p_soft_reset;
      (frame_stb && pend_q) |=> main_q == MAIN_RST && loff_q == LOFF_RST && !pend_q;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not complete");

   property p_soft_arm;
      (wr_main && fr_data[SRST_POS]) |=> pend_q && !main_q[SRST_POS] ##1 pend_q;
   endproperty
   a_soft_arm: assert property (p_soft_arm) else $error("soft reset not armed");

   property p_write_main;
      wr_main |=> main_q == ($past(fr_data) & MAIN_WMASK & 24'hFFFFFE);
   endproperty
   a_write_main: assert property (p_write_main) else $error("main write lost");

   property p_read_word;
      rd_frame |=> rdata_q[31] == 1'b0 && rdata_q[30:24] == $past(fr_addr);
   endproperty
   a_read_word: assert property (p_read_word) else $error("read answer malformed");

   property p_hw_reset;
      $fell(srst_in) |-> main_q == MAIN_RST && !pend_q;
   endproperty
   a_hw_reset: assert property (@(posedge clock_in) p_hw_reset) else $error("reset value wrong");

   property p_reserved;
      (main_q & ~MAIN_WMASK) == 24'h000000 && (loff_q & ~LOFF_WMASK) == 24'h000000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_loff_write;
      wr_loff |=> loff_q == ($past(fr_data) & LOFF_WMASK);
   endproperty
   a_loff_write: assert property (p_loff_write) else $error("lead-off write lost");

   property p_clk_io;
      (main_q[GANG_POS] && main_q[MASTER_POS] && main_q[PWR_POS] && !SLAVE_ONLY)
         |=> clk_io_oe_out;
   endproperty
   a_clk_io: assert property (p_clk_io) else $error("master left clock pin idle");

   property p_refbuf;
      1'b1 |=> reference_buffer_en_out == $past(main_q[REFBUF_POS]);
   endproperty
   a_refbuf: assert property (p_refbuf) else $error("reference buffer level wrong");

   property p_conv_run;
      (main_q[CONV_POS] && main_q[PWR_POS]) |=> conversion_run_out;
   endproperty
   a_conv_run: assert property (p_conv_run) else $error("conversion not started");

   property p_read_main;
      (rd_frame && fr_addr == ADDR_MAIN) |=> rdata_q[23:0] == $past(main_q);
   endproperty
   a_read_main: assert property (p_read_main) else $error("main read data wrong");

   property p_crystal_on;
      (main_q[PWR_POS] && !main_q[EXTCLK_POS] && !main_q[GANG_POS])
         |=> crystal_oscillator_en_out;
   endproperty
   a_crystal_on: assert property (p_crystal_on) else $error("crystal off while selected");

   // Main scenarios worth seeing
   c_master: cover property (master_active_out && sync_oe_out);
   c_soft_reset: cover property (pend_q ##[1:1000] frame_stb ##1 !pend_q);
   c_read_main: cover property (rd_frame && fr_addr == ADDR_MAIN);
   c_running: cover property (conversion_run_out && high_rate_sel_out);
   c_gain_fallback: cover property (main_q[GAIN_HI:GAIN_LO] == GAIN_X4P2 && !gain_cal_done_in);
endmodule : eaf_main_control

/* File: bench/eaf_host_model.sv */
/*
 * Behavioural host on the far side of the serial link: sends 32-bit words
 * MSB first and captures the word the device shifts back in the same frame.
 * Assumes the testbench calls frame() one at a time; clock stops between frames.
 */
module eaf_host_model (
   // Link pins
   output logic link_clk_out,
   output logic cs_n_out,
   output logic sdi_out,
   input wire logic sdo_in,
   // Captured answer, toggle marks a complete frame
   output logic [31:0] ans_word_out,
   output logic ans_tgl_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle levels before the first frame
   initial begin
      link_clk_out = 1'b0;
      cs_n_out = 1'b1;
      sdi_out = 1'b0;
      ans_word_out = 32'h00000000;
      ans_tgl_out = 1'b0;
   end

   // One frame of nbits; short frames exist only to be refused
   task automatic frame(input logic [31:0] word, input int nbits);
      logic [31:0] ans;
      int k;
      ans = 32'h00000000;
      #7; // Odd offset keeps the link clock out of phase with the core clock
      cs_n_out = 1'b0;
      for (k = 0; k < nbits; k++) begin
         sdi_out = word[31-k];
         #40;
         ans[31-k] = sdo_in;
         link_clk_out = 1'b1;
         #40;
         link_clk_out = 1'b0;
      end
      cs_n_out = 1'b1;
      sdi_out = ~sdi_out; // Released line must not keep showing the last bit
      if (nbits == 32) begin
         ans_word_out = ans;
         ans_tgl_out = ~ans_tgl_out;
      end
      #300; // Select high long enough for the core to take the word
   endtask : frame
endmodule : eaf_host_model

/* File: bench/testbench.sv */
/*
 * Self-checking bench for the main control register bank: writes, reads,
 * masking, unmapped addresses, short frames and the two-step soft reset.
 * Assumes the host model drives the link and a slave-only copy shares it.
 */
module testbench
   import eaf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clock_in = 1'b0;
   logic srst_in = 1'b1;
   logic gain_cal_done_in = 1'b0;
   logic link_clk, cs_n, sdi, sdo, ans_tgl, pend, so_master;
   logic [31:0] ans_word;
   logic [1:0] gain;
   logic refbuf, extclk, crys, clkoe, syncact, syncoe, master, hirate, conv, pwr;
   logic [23:0] main_ctl, loff_ctl;
   logic [23:0] main_m = 24'h000000;
   logic [23:0] loff_m = 24'h000000;
   logic [31:0] last_ans = 32'h00000000;
   logic [31:0] exp_q[$];
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   int seed = 32'hd737;
   bit started = 1'b0;
   logic [23:0] dir_tab[6] = '{24'h000010, 24'h000030, 24'h000020, 24'h000086,
                               24'h000302, 24'h000046};

   // Core clock, 10 ns
   initial begin
      forever #5 clock_in = ~clock_in;
   end

   eaf_host_model i_eaf_host_model (.link_clk_out(link_clk), .cs_n_out(cs_n),
      .sdi_out(sdi), .sdo_in(sdo), .ans_word_out(ans_word), .ans_tgl_out(ans_tgl));

   eaf_main_control #(.SLAVE_ONLY(1'b0)) i_eaf_main_control (.clock_in(clock_in),
      .srst_in(srst_in), .link_clk_in(link_clk), .cs_n_in(cs_n), .sdi_in(sdi),
      .sdo_out(sdo), .gain_cal_done_in(gain_cal_done_in), .gain_out(gain),
      .reference_buffer_en_out(refbuf), .external_clock_sel_out(extclk),
      .crystal_oscillator_en_out(crys), .clk_io_oe_out(clkoe), .sync_active_out(syncact),
      .sync_oe_out(syncoe), .master_active_out(master), .high_rate_sel_out(hirate),
      .conversion_run_out(conv), .analog_power_out(pwr), .soft_reset_pend_out(pend),
      .main_control_out(main_ctl), .lead_off_control_out(loff_ctl));

   // Slave-only copy listens to the same frames; only its master_active_out output matters
   eaf_main_control #(.SLAVE_ONLY(1'b1)) i_eaf_main_control_slave (.clock_in(clock_in),
      .srst_in(srst_in), .link_clk_in(link_clk), .cs_n_in(cs_n), .sdi_in(sdi),
      .sdo_out(), .gain_cal_done_in(gain_cal_done_in), .gain_out(),
      .reference_buffer_en_out(), .external_clock_sel_out(), .crystal_oscillator_en_out(),
      .clk_io_oe_out(), .sync_active_out(), .sync_oe_out(), .master_active_out(so_master),
      .high_rate_sel_out(), .conversion_run_out(), .analog_power_out(),
      .soft_reset_pend_out(), .main_control_out(), .lead_off_control_out());

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic print_verdict();
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   // Expected control levels, worked out from the stored register value
   function automatic logic [11:0] ctl_exp(input logic [23:0] v, input logic cal);
      logic gang, mst, slv;
      logic [1:0] g;
      gang = v[GANG_POS];
      mst = gang & v[MASTER_POS];
      slv = gang & !mst;
      g = (v[GAIN_HI:GAIN_LO] == GAIN_X4P2 && !cal) ? GAIN_X2P8 : v[GAIN_HI:GAIN_LO];
      return {g, v[REFBUF_POS], v[EXTCLK_POS] | slv, v[PWR_POS] & !v[EXTCLK_POS] & !slv,
              mst & v[PWR_POS], gang, mst, mst, v[HIRATE_POS], v[CONV_POS] & v[PWR_POS],
              v[PWR_POS]};
   endfunction : ctl_exp

   task automatic check_ctl();
      repeat (10) @(posedge clock_in);
      #1; // Look once the edge's outputs have settled
      check("controls", {20'h0, ctl_exp(main_m, gain_cal_done_in)}, {20'h0, gain, refbuf,
            extclk, crys, clkoe, syncact, syncoe, master, hirate, conv, pwr});
      check("main register", {8'h0, main_m}, {8'h0, main_ctl});
      check("lead-off register", {8'h0, loff_m}, {8'h0, loff_ctl});
      check("slave-only master", 32'h0, {31'h0, so_master});
   endtask : check_ctl

   // Every frame returns the previous read answer, or 0 after a reset
   task automatic wr(input logic [6:0] addr, input logic [23:0] data, input logic cal);
      @(posedge clock_in);
      gain_cal_done_in <= cal;
      exp_q.push_back(last_ans);
      i_eaf_host_model.frame({1'b1, addr, data}, 32);
      // The reset request bit clears itself and is never stored
      if (addr == ADDR_MAIN) main_m = data & MAIN_WMASK & ~(24'h000001 << SRST_POS);
      if (addr == ADDR_LOFF) loff_m = data & LOFF_WMASK;
      check_ctl();
   endtask : wr

   task automatic rd(input logic [6:0] addr);
      exp_q.push_back(last_ans);
      i_eaf_host_model.frame({1'b0, addr, 24'h000000}, 32);
      last_ans = {1'b0, addr, addr == ADDR_MAIN ? main_m : addr == ADDR_LOFF ? loff_m : 24'h0};
   endtask : rd

   // Watcher: each complete frame's answer is compared with the oldest note
   always @(ans_tgl) begin
      if (started) begin
         if (exp_q.size() == 0) begin
            check("answer queue", 32'h1, 32'h0);
         end else begin
            check("read answer", exp_q.pop_front(), ans_word);
         end
      end
   end

   // Hang guard, well above the roughly 11,600 cycles of frames below
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         print_verdict();
      end
   end

   initial begin
      repeat (10) @(posedge clock_in);
      srst_in <= 1'b0;
      started = 1'b1;
      check_ctl();
      rd(ADDR_MAIN);
      foreach (dir_tab[i]) begin
         wr(ADDR_MAIN, dir_tab[i], i[0]);
         rd(ADDR_MAIN);
      end
      repeat (8) begin
         wr(ADDR_MAIN, $random(seed) & 24'hFFFFFE, $random(seed));
         rd(ADDR_MAIN);
      end
      wr(ADDR_LOFF, $random(seed), 1'b0);
      rd(ADDR_LOFF);
      wr(7'h05, 24'hFFFFFF, 1'b0);
      rd(7'h05);
      // Short frame must leave everything untouched
      i_eaf_host_model.frame({1'b1, ADDR_MAIN, 24'h0000FF}, 16);
      check_ctl();
      rd(ADDR_MAIN);
      wr(ADDR_MAIN, 24'h000007, 1'b1);
      check("reset pending", 32'h1, {31'h0, pend});
      exp_q.push_back(last_ans);
      i_eaf_host_model.frame(32'h00000000, 32);
      main_m = 24'h000000;
      loff_m = 24'h000000;
      last_ans = 32'h00000000;
      check_ctl();
      check("reset pending", 32'h0, {31'h0, pend});
      rd(ADDR_LOFF);
      rd(ADDR_MAIN);
      rd(ADDR_NOP);
      repeat (20) @(posedge clock_in);
      check("notes left", 32'h0, exp_q.size());
      print_verdict();
   end
endmodule : testbench
